// ==== hw/sbp_defines.svh ====
// Offsets, field positions, reset values and timing counts of the base register bank
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define SBP_IDX_NODE        6'h00
`define SBP_IDX_RESET_GAP   6'h01
`define SBP_IDX_EXT_PORTS   6'h02
`define SBP_IDX_SPEED_SBY   6'h03
`define SBP_IDX_LINK_PWR    6'h04
`define SBP_IDX_IRQ_FEAT    6'h05
`define SBP_IDX_LEGACY      6'h06
`define SBP_IDX_PAGE_PORT   6'h07
`define SBP_IDX_PAGED_LO    6'h08
`define SBP_IDX_PAGED_HI    6'h0f
`define SBP_IDX_IRQ_STATUS  6'h10
`define SBP_IDX_IRQ_MASK    6'h11

// ============================================================
// Field positions in 7..0 numbering (position 7 is bit 7)
`define SBP_F_RHB           7
`define SBP_F_IBR           6
`define SBP_F_STANDBY_ENABLE          4
`define SBP_F_LCTRL         7
`define SBP_F_CONT          6
`define SBP_F_WDIE          7
`define SBP_F_SHORT_RESET_REQUEST          6

// ============================================================
// Constant codes and reset values
`define SBP_GAP_RESET       6'h3f
`define SBP_EXT_CODE        3'h7
`define SBP_NUM_PORTS       4'h3
`define SBP_SPEED_CODE      3'h7
`define SBP_DELAY_CODE      4'hf
`define SBP_JITTER_CODE     3'h0
`define SBP_LCTRL_RESET     1'b1
`define SBP_PWR_RESET       3'h0

// ============================================================
// Interrupt status bit positions
`define SBP_IRQ_SELFID      0
`define SBP_IRQ_BUSRST      1
`define SBP_IRQ_CPSLOW      2
`define SBP_IRQ_LRDONE      3
`define SBP_IRQ_W           4

// ============================================================
// Timing
`define SBP_CLK_PERIOD_NS   5
`define SBP_LONG_RESET_NS   166000
`define SBP_LONG_RESET_CYCLES ((`SBP_LONG_RESET_NS + `SBP_CLK_PERIOD_NS - 1) / `SBP_CLK_PERIOD_NS)

`endif

// ==== hw/sbp_pkg.sv ====
// Types shared by the base register bank modules
package sbp_pkg;

  // ============================================================
  // Bus slave handshake states
  typedef enum logic {
    SBP_BUS_IDLE,
    SBP_BUS_ACK
  } sbp_bus_state_e;

  // ============================================================
  // Long bus reset sequencer states
  typedef enum logic {
    SBP_LR_IDLE,
    SBP_LR_RUN
  } sbp_lr_state_e;

endpackage

// ==== hw/sbp_reg_if.sv ====
// Register access carrier between the bus slave and the register bank
interface sbp_reg_if;
  logic        wr_stb;
  logic [5:0]  index;
  logic [7:0]  wdata;
  logic [31:0] rdata;

  modport ctrl (output wr_stb, output index, output wdata, input rdata);
  modport regs (input wr_stb, input index, input wdata, output rdata);
endinterface

// ==== hw/sbp_avalon_slave.sv ====
// Avalon-MM slave with waitrequest driving the register access carrier
module sbp_avalon_slave #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Avalon-MM
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Register side
  sbp_reg_if.ctrl                bus
);

  sbp_pkg::sbp_bus_state_e state_reg, state_next;
  logic [31:0]             readdata_next;
  logic                    waitrequest_next;

  // ============================================================
  // Request decode toward the register bank
  assign bus.index  = address[7:2];
  assign bus.wdata  = writedata[7:0];
  assign bus.wr_stb = (state_reg == sbp_pkg::SBP_BUS_ACK) && write && byteenable[0];

  // ============================================================
  // Handshake next state: one wait cycle, then answer
  always_comb begin
    state_next       = state_reg;
    readdata_next    = readdata;
    waitrequest_next = waitrequest;
    case (state_reg)
      sbp_pkg::SBP_BUS_IDLE: begin
        if (read || write) begin
          state_next       = sbp_pkg::SBP_BUS_ACK;
          readdata_next    = bus.rdata;
          waitrequest_next = 1'b0;
        end
      end
      sbp_pkg::SBP_BUS_ACK: begin
        state_next       = sbp_pkg::SBP_BUS_IDLE;
        waitrequest_next = 1'b1;
      end
      default: begin
        state_next       = sbp_pkg::SBP_BUS_IDLE;
        waitrequest_next = 1'b1;
      end
    endcase
  end

  // ============================================================
  // Handshake registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= sbp_pkg::SBP_BUS_IDLE;
      readdata    <= 32'h0000_0000;
      waitrequest <= 1'b1;
    end else if (ce) begin
      state_reg   <= state_next;
      readdata    <= readdata_next;
      waitrequest <= waitrequest_next;
    end
  end

endmodule

// ==== hw/sbp_gap_ctrl.sv ====
// Arbitration gap count with recovery after two idle bus resets
`include "sbp_defines.svh"

module sbp_gap_ctrl (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Events
  input  wire logic       bus_rst,
  input  wire logic       upd,
  input  wire logic [5:0] upd_val,
  // Result
  output logic      [5:0] gap_count
);

  logic [5:0] gap_next;
  logic       stale_reg, stale_next;

  // ============================================================
  // Stale marks a bus reset seen with no update since
  always_comb begin
    gap_next   = gap_count;
    stale_next = stale_reg;
    if (bus_rst) begin
      if (stale_reg) begin
        gap_next = `SBP_GAP_RESET;
      end
      stale_next = 1'b1;
    end
    if (upd) begin
      gap_next   = upd_val;
      stale_next = 1'b0;
    end
  end

  // ============================================================
  // Gap registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_count <= `SBP_GAP_RESET;
      stale_reg <= 1'b0;
    end else if (ce) begin
      gap_count <= gap_next;
      stale_reg <= stale_next;
    end
  end

endmodule

// ==== hw/sbp_base_regs.sv ====
// Base configuration and status register bank of a three-port serial bus PHY
`include "sbp_defines.svh"

module sbp_base_regs #(
  parameter int LONG_RESET_CYCLES = `SBP_LONG_RESET_CYCLES
) (
  // Clock, enable and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // Avalon-MM register bus
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Events from the PHY core
  input  wire logic        BUS_RESET_IN,
  input  wire logic        SELF_ID_DONE,
  input  wire logic [5:0]  SELF_ID_NODE,
  input  wire logic        ROOT_WON,
  input  wire logic        LINK_IDLE,
  input  wire logic        CFG_VALID,
  input  wire logic        CFG_RHB,
  input  wire logic        CFG_GAP_VALID,
  input  wire logic [5:0]  CFG_GAP,
  input  wire logic        STANDBY_CMD,
  // Cable power sense pin
  input  wire logic        CPS_PIN,
  // Status and control toward the PHY core and link
  output logic             NODE_VALID,
  output logic             STATUS_XFER_VALID,
  output logic      [7:0]  STATUS_XFER_DATA,
  output logic             ROOT_HOLDOFF,
  output logic             LONG_RESET_ACTIVE,
  output logic             SHORT_RESET_REQ,
  output logic      [5:0]  GAP_COUNT,
  output logic             STANDBY_ENTER,
  output logic             IRQ
);

  localparam int LR_CNT_W = $clog2(LONG_RESET_CYCLES + 1);

  sbp_reg_if reg_bus ();

  // ============================================================
  // State declarations
  logic [5:0]              node_reg, node_next;
  logic                    node_valid_next;
  logic                    root_reg, root_next;
  logic                    rhb_next;
  logic                    ibr_reg, ibr_next;
  logic                    standby_enable_reg, standby_enable_next;
  logic                    lctrl_reg, lctrl_next;
  logic                    cont_reg, cont_next;
  logic [2:0]              pwr_reg, pwr_next;
  logic                    wdie_reg, wdie_next;
  logic                    short_reset_request_next;
  logic [2:0]              page_reg, page_next;
  logic [3:0]              port_sel_reg, port_sel_next;
  logic [`SBP_IRQ_W-1:0]   irq_stat_reg, irq_stat_next;
  logic [`SBP_IRQ_W-1:0]   irq_mask_reg, irq_mask_next;
  logic                    irq_next;
  logic                    xfer_valid_next;
  logic [7:0]              xfer_data_next;
  logic                    standby_next;
  sbp_pkg::sbp_lr_state_e  lr_state_reg, lr_state_next;
  logic [LR_CNT_W-1:0]     lr_cnt_reg, lr_cnt_next;
  logic                    lr_active_next;
  logic                    lr_start;
  logic                    lr_done;
  logic                    bus_rst;
  logic                    cps_meta_reg, cps_sync_reg, cps_last_reg;
  logic                    cps_low_evt;
  logic                    gap_upd;
  logic [5:0]              gap_upd_val;
  logic [7:0]              rd_byte;
  logic                    wr_r1, wr_r3, wr_r4, wr_r5, wr_r7, wr_stat, wr_mask;

  // ============================================================
  // Register 0 layout: node number, root, cable power
  function automatic logic [7:0] reg0_value(input logic [5:0] node, input logic root, input logic cable_power_sense);
    reg0_value = {node, root, cable_power_sense};
  endfunction

  // ============================================================
  // Bus slave
  sbp_avalon_slave #(
    .ADDR_W (8)
  ) u_slave (
    .clk         (CLK),
    .rst_n       (RST_N),
    .ce          (CE),
    .address     (AVS_ADDRESS),
    .read        (AVS_READ),
    .write       (AVS_WRITE),
    .writedata   (AVS_WRITEDATA),
    .byteenable  (AVS_BYTEENABLE),
    .readdata    (AVS_READDATA),
    .waitrequest (AVS_WAITREQUEST),
    .bus         (reg_bus.ctrl)
  );

  // ============================================================
  // Cable power sense synchroniser and drop detect
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cps_meta_reg <= 1'b0;
      cps_sync_reg <= 1'b0;
      cps_last_reg <= 1'b0;
    end else if (CE) begin
      cps_meta_reg <= CPS_PIN;
      cps_sync_reg <= cps_meta_reg;
      cps_last_reg <= cps_sync_reg;
    end
  end

  assign cps_low_evt = cps_last_reg && !cps_sync_reg;

  // ============================================================
  // Write strobes per register
  assign wr_r1   = reg_bus.wr_stb && (reg_bus.index == `SBP_IDX_RESET_GAP);
  assign wr_r3   = reg_bus.wr_stb && (reg_bus.index == `SBP_IDX_SPEED_SBY);
  assign wr_r4   = reg_bus.wr_stb && (reg_bus.index == `SBP_IDX_LINK_PWR);
  assign wr_r5   = reg_bus.wr_stb && (reg_bus.index == `SBP_IDX_IRQ_FEAT);
  assign wr_r7   = reg_bus.wr_stb && (reg_bus.index == `SBP_IDX_PAGE_PORT);
  assign wr_stat = reg_bus.wr_stb && (reg_bus.index == `SBP_IDX_IRQ_STATUS);
  assign wr_mask = reg_bus.wr_stb && (reg_bus.index == `SBP_IDX_IRQ_MASK);

  // ============================================================
  // Bus reset is an external one or the start of our long reset
  assign bus_rst = BUS_RESET_IN || lr_start;

  // ============================================================
  // Gap count source: register write or configuration packet
  assign gap_upd     = wr_r1 || (CFG_VALID && CFG_GAP_VALID);
  assign gap_upd_val = wr_r1 ? reg_bus.wdata[5:0] : CFG_GAP;

  sbp_gap_ctrl u_gap (
    .clk       (CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .bus_rst   (bus_rst),
    .upd       (gap_upd),
    .upd_val   (gap_upd_val),
    .gap_count (GAP_COUNT)
  );

  // ============================================================
  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (reg_bus.index == `SBP_IDX_NODE) begin
      rd_byte = reg0_value(node_reg, root_reg, cps_sync_reg);
    end else if (reg_bus.index == `SBP_IDX_RESET_GAP) begin
      rd_byte = {ROOT_HOLDOFF, ibr_reg, GAP_COUNT};
    end else if (reg_bus.index == `SBP_IDX_EXT_PORTS) begin
      rd_byte = {`SBP_EXT_CODE, 1'b0, `SBP_NUM_PORTS};
    end else if (reg_bus.index == `SBP_IDX_SPEED_SBY) begin
      rd_byte = {`SBP_SPEED_CODE, standby_enable_reg, `SBP_DELAY_CODE};
    end else if (reg_bus.index == `SBP_IDX_LINK_PWR) begin
      rd_byte = {lctrl_reg, cont_reg, `SBP_JITTER_CODE, pwr_reg};
    end else if (reg_bus.index == `SBP_IDX_IRQ_FEAT) begin
      rd_byte = {wdie_reg, SHORT_RESET_REQ, 6'h00};
    end else if (reg_bus.index == `SBP_IDX_PAGE_PORT) begin
      rd_byte = {page_reg, 1'b0, port_sel_reg};
    end else if (reg_bus.index >= `SBP_IDX_PAGED_LO && reg_bus.index <= `SBP_IDX_PAGED_HI) begin
      rd_byte = 8'h00;
    end else if (reg_bus.index == `SBP_IDX_IRQ_STATUS) begin
      rd_byte = {4'h0, irq_stat_reg};
    end else if (reg_bus.index == `SBP_IDX_IRQ_MASK) begin
      rd_byte = {4'h0, irq_mask_reg};
    end
  end

  assign reg_bus.rdata = {24'h00_0000, rd_byte};

  // ============================================================
  // Long bus reset sequencer
  always_comb begin
    lr_state_next  = lr_state_reg;
    lr_cnt_next    = lr_cnt_reg;
    lr_start       = 1'b0;
    lr_done        = 1'b0;
    case (lr_state_reg)
      sbp_pkg::SBP_LR_IDLE: begin
        if (ibr_reg && LINK_IDLE) begin
          lr_state_next = sbp_pkg::SBP_LR_RUN;
          lr_cnt_next   = LR_CNT_W'(LONG_RESET_CYCLES - 1);
          lr_start      = 1'b1;
        end
      end
      sbp_pkg::SBP_LR_RUN: begin
        if (lr_cnt_reg == '0) begin
          lr_state_next = sbp_pkg::SBP_LR_IDLE;
          lr_done       = 1'b1;
        end else begin
          lr_cnt_next = lr_cnt_reg - 1'b1;
        end
      end
      default: begin
        lr_state_next = sbp_pkg::SBP_LR_IDLE;
      end
    endcase
    lr_active_next = (lr_state_next == sbp_pkg::SBP_LR_RUN);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      lr_state_reg      <= sbp_pkg::SBP_LR_IDLE;
      lr_cnt_reg        <= '0;
      LONG_RESET_ACTIVE <= 1'b0;
    end else if (CE) begin
      lr_state_reg      <= lr_state_next;
      lr_cnt_reg        <= lr_cnt_next;
      LONG_RESET_ACTIVE <= lr_active_next;
    end
  end

  // ============================================================
  // Node identity, root and status transfer
  always_comb begin
    node_next       = node_reg;
    node_valid_next = NODE_VALID;
    root_next       = root_reg;
    xfer_valid_next = 1'b0;
    xfer_data_next  = STATUS_XFER_DATA;
    if (bus_rst) begin
      node_valid_next = 1'b0;
      root_next       = 1'b0;
    end
    if (ROOT_WON) begin
      root_next = 1'b1;
    end
    if (SELF_ID_DONE) begin
      node_next       = SELF_ID_NODE;
      node_valid_next = 1'b1;
      xfer_valid_next = 1'b1;
      xfer_data_next  = reg0_value(SELF_ID_NODE, root_next, cps_sync_reg);
    end
  end

  // ============================================================
  // Control fields written by software or packets
  always_comb begin
    rhb_next      = ROOT_HOLDOFF;
    ibr_next      = ibr_reg;
    standby_enable_next     = standby_enable_reg;
    lctrl_next    = lctrl_reg;
    cont_next     = cont_reg;
    pwr_next      = pwr_reg;
    wdie_next     = wdie_reg;
    short_reset_request_next     = SHORT_RESET_REQ;
    page_next     = page_reg;
    port_sel_next = port_sel_reg;
    if (wr_r1) begin
      rhb_next = reg_bus.wdata[`SBP_F_RHB];
      ibr_next = reg_bus.wdata[`SBP_F_IBR];
    end
    if (CFG_VALID) begin
      rhb_next = CFG_RHB;
    end
    if (bus_rst) begin
      ibr_next  = 1'b0;
      short_reset_request_next = 1'b0;
    end
    if (wr_r3) begin
      standby_enable_next = reg_bus.wdata[`SBP_F_STANDBY_ENABLE];
    end
    if (wr_r4) begin
      lctrl_next = reg_bus.wdata[`SBP_F_LCTRL];
      cont_next  = reg_bus.wdata[`SBP_F_CONT];
      pwr_next   = reg_bus.wdata[2:0];
    end
    if (wr_r5) begin
      wdie_next = reg_bus.wdata[`SBP_F_WDIE];
      if (reg_bus.wdata[`SBP_F_SHORT_RESET_REQUEST]) begin
        short_reset_request_next = 1'b1;
      end
    end
    if (wr_r7) begin
      page_next     = reg_bus.wdata[7:5];
      port_sel_next = reg_bus.wdata[3:0];
    end
    standby_next = STANDBY_CMD && standby_enable_reg;
  end

  // ============================================================
  // Interrupt status, mask and output
  always_comb begin
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_reg & ~reg_bus.wdata[`SBP_IRQ_W-1:0];
    end
    if (wr_mask) begin
      irq_mask_next = reg_bus.wdata[`SBP_IRQ_W-1:0];
    end
    if (SELF_ID_DONE) begin
      irq_stat_next[`SBP_IRQ_SELFID] = 1'b1; // Set wins over clear
    end
    if (bus_rst) begin
      irq_stat_next[`SBP_IRQ_BUSRST] = 1'b1;
    end
    if (cps_low_evt) begin
      irq_stat_next[`SBP_IRQ_CPSLOW] = 1'b1;
    end
    if (lr_done) begin
      irq_stat_next[`SBP_IRQ_LRDONE] = 1'b1;
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // ============================================================
  // Register stage for identity, control and interrupts
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      node_reg          <= 6'h00;
      NODE_VALID        <= 1'b0;
      root_reg          <= 1'b0;
      STATUS_XFER_VALID <= 1'b0;
      STATUS_XFER_DATA  <= 8'h00;
      ROOT_HOLDOFF      <= 1'b0;
      ibr_reg           <= 1'b0;
      standby_enable_reg          <= 1'b0;
      lctrl_reg         <= `SBP_LCTRL_RESET;
      cont_reg          <= 1'b0;
      pwr_reg           <= `SBP_PWR_RESET;
      wdie_reg          <= 1'b0;
      SHORT_RESET_REQ   <= 1'b0;
      page_reg          <= 3'h0;
      port_sel_reg      <= 4'h0;
      STANDBY_ENTER     <= 1'b0;
      irq_stat_reg      <= '0;
      irq_mask_reg      <= '0;
      IRQ               <= 1'b0;
    end else if (CE) begin
      node_reg          <= node_next;
      NODE_VALID        <= node_valid_next;
      root_reg          <= root_next;
      STATUS_XFER_VALID <= xfer_valid_next;
      STATUS_XFER_DATA  <= xfer_data_next;
      ROOT_HOLDOFF      <= rhb_next;
      ibr_reg           <= ibr_next;
      standby_enable_reg          <= standby_enable_next;
      lctrl_reg         <= lctrl_next;
      cont_reg          <= cont_next;
      pwr_reg           <= pwr_next;
      wdie_reg          <= wdie_next;
      SHORT_RESET_REQ   <= short_reset_request_next;
      page_reg          <= page_next;
      port_sel_reg      <= port_sel_next;
      STANDBY_ENTER     <= standby_next;
      irq_stat_reg      <= irq_stat_next;
      irq_mask_reg      <= irq_mask_next;
      IRQ               <= irq_next;
    end
  end

endmodule

// ==== tb/sbp_base_regs_checker.sv ====
// Port checks on the base register bank
`include "sbp_defines.svh"

module sbp_base_regs_checker #(
  parameter int LONG_RESET_CYCLES = `SBP_LONG_RESET_CYCLES
) (
  // ====
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Inputs
  input wire logic        AVS_WRITE,
  input wire logic        BUS_RESET_IN,
  input wire logic        SELF_ID_DONE,
  input wire logic [5:0]  SELF_ID_NODE,
  input wire logic        LINK_IDLE,
  input wire logic        CFG_VALID,
  input wire logic        CFG_GAP_VALID,
  input wire logic [5:0]  CFG_GAP,
  input wire logic        STANDBY_CMD,
  // Outputs
  input wire logic        AVS_WAITREQUEST,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        NODE_VALID,
  input wire logic        STATUS_XFER_VALID,
  input wire logic [7:0]  STATUS_XFER_DATA,
  input wire logic        LONG_RESET_ACTIVE,
  input wire logic [5:0]  GAP_COUNT,
  input wire logic        STANDBY_ENTER
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [15:0] lr_cnt_reg;
  // Length of the running long reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) lr_cnt_reg <= 16'h0000;
    else lr_cnt_reg <= LONG_RESET_ACTIVE ? lr_cnt_reg + 16'h0001 : 16'h0000;
  end
  chk_selfid_answer: assert property (SELF_ID_DONE |=> STATUS_XFER_VALID && NODE_VALID)
    else $error("self-id answer missing");
  chk_selfid_node: assert property (SELF_ID_DONE |=> STATUS_XFER_DATA[7:2] == $past(SELF_ID_NODE))
    else $error("transfer node wrong");
  chk_reset_invalid: assert property (BUS_RESET_IN && !SELF_ID_DONE |=> !NODE_VALID)
    else $error("node stays valid");
  chk_lr_idle: assert property ($rose(LONG_RESET_ACTIVE) |-> $past(LINK_IDLE))
    else $error("long reset while busy");
  chk_lr_length: assert property ($fell(LONG_RESET_ACTIVE) |-> lr_cnt_reg == LONG_RESET_CYCLES)
    else $error("long reset length wrong");
  chk_standby_cause: assert property (STANDBY_ENTER |-> $past(STANDBY_CMD))
    else $error("standby without command");
  chk_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  chk_upper_zero: assert property (AVS_READDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_gap_packet: assert property (CFG_VALID && CFG_GAP_VALID && !AVS_WRITE && !BUS_RESET_IN
    |=> GAP_COUNT == $past(CFG_GAP))
    else $error("packet gap not taken");
endmodule

bind sbp_base_regs sbp_base_regs_checker #(.LONG_RESET_CYCLES(LONG_RESET_CYCLES)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .AVS_WRITE(AVS_WRITE), .BUS_RESET_IN(BUS_RESET_IN),
  .SELF_ID_DONE(SELF_ID_DONE), .SELF_ID_NODE(SELF_ID_NODE), .LINK_IDLE(LINK_IDLE),
  .CFG_VALID(CFG_VALID), .CFG_GAP_VALID(CFG_GAP_VALID), .CFG_GAP(CFG_GAP),
  .STANDBY_CMD(STANDBY_CMD), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
  .NODE_VALID(NODE_VALID), .STATUS_XFER_VALID(STATUS_XFER_VALID), .STATUS_XFER_DATA(STATUS_XFER_DATA),
  .LONG_RESET_ACTIVE(LONG_RESET_ACTIVE), .GAP_COUNT(GAP_COUNT), .STANDBY_ENTER(STANDBY_ENTER));

// ==== tb/sbp_core_model.sv ====
// Behavioural PHY core raising bus events
module sbp_core_model (
  // Clock
  input wire logic   clk,
  // Events
  output logic       br,
  output logic       sd,
  output logic [5:0] sn,
  output logic       rw,
  output logic       cv,
  output logic       gv,
  output logic       crh,
  output logic [5:0] cg,
  output logic       sby,
  output logic       idle
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Quiet bus, link idle
  initial begin
    {br, sd, sn, rw, cv, gv, crh, cg, sby} = '0;
    idle = 1'b1;
  end
  // One-cycle event: 0 reset, 1 self-id, 2 gap packet, 3 holdoff packet without gap, 4 standby, 5 root
  task automatic pulse(input int k, input logic [5:0] v);
    @(posedge clk);
    br <= (k == 0);
    sd <= (k == 1);
    sn <= v;
    cv <= (k == 2) || (k == 3);
    gv <= (k == 2);
    cg <= v;
    crh <= (k == 3);
    sby <= (k == 4);
    rw <= (k == 5);
    @(posedge clk);
    {br, sd, rw, cv, gv, crh, sby} <= '0;
  endtask
  // Link activity level, changed just after an edge
  task automatic set_idle(input logic v);
    @(posedge clk);
    idle <= v;
  endtask
endmodule

// ==== tb/sbp_base_regs_tb_top.sv ====
// Self-checking bench of the base register bank
module sbp_base_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  localparam int LR = 20;
  localparam logic [7:0] RV [8] = '{8'h00, 8'h3f, 8'he3, 8'hef, 8'h80, 8'h00, 8'h00, 8'h00};
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, cable_power_sense = 0;
  logic [7:0] adr = 0, wd = 0, q, xd;
  logic [31:0] rdat;
  logic wreq, nv, xv, rh, lra, sen, irq, srq, br, sd, rw, cv, gv, crh, sby, idle;
  logic [5:0] gap, sn, cg;
  int fails = 0, samples_checked = 0, cyc = 0;
  // Clock and timeout
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test;
    end
  end
  sbp_base_regs #(.LONG_RESET_CYCLES(LR)) dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA({24'h000000, wd}),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .BUS_RESET_IN(br),
    .SELF_ID_DONE(sd), .SELF_ID_NODE(sn), .ROOT_WON(rw), .LINK_IDLE(idle), .CFG_VALID(cv),
    .CFG_RHB(crh), .CFG_GAP_VALID(gv), .CFG_GAP(cg), .STANDBY_CMD(sby), .CPS_PIN(cable_power_sense),
    .NODE_VALID(nv), .STATUS_XFER_VALID(xv), .STATUS_XFER_DATA(xd), .ROOT_HOLDOFF(rh),
    .LONG_RESET_ACTIVE(lra), .SHORT_RESET_REQ(srq), .GAP_COUNT(gap), .STANDBY_ENTER(sen), .IRQ(irq));
  sbp_core_model core (.clk(clk), .br(br), .sd(sd), .sn(sn), .rw(rw), .cv(cv), .gv(gv), .crh(crh),
    .cg(cg), .sby(sby), .idle(idle));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Avalon cycle held until waitrequest is sampled low; only the timeout ends a wait
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= {i, 2'b00};
    wd <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      bus(0, i, 0);
      chk("reset value", RV[i], q);
    end
    bus(0, 6'h08, 0);
    chk("paged", 8'h00, q);
    bus(0, 6'h20, 0);
    chk("unmapped", 8'h00, q);
  endtask
  task automatic t_ro;
    bus(1, 2, 8'h00);
    bus(1, 3, 8'h10);
    bus(1, 7, 8'hf5);
    bus(0, 2, 0);
    chk("reg2", 8'he3, q);
    bus(0, 3, 0);
    chk("reg3", 8'hff, q);
    bus(0, 7, 0);
    chk("reg7", 8'he5, q);
    bus(0, 6'h08, 0);
    chk("paged page7", 8'h00, q);
    core.pulse(4, 0);
    #1 chk("standby", 1, sen);
  endtask
  task automatic t_sid;
    @(posedge clk);
    cable_power_sense <= 1;
    repeat (4) @(posedge clk);
    core.pulse(1, 6'h15);
    #1 chk("xfer valid", 1, xv);
    chk("xfer data", 8'h55, xd);
    core.pulse(5, 0);
    bus(0, 0, 0);
    chk("reg0 root", 8'h57, q);
    core.pulse(0, 0);
    #1 chk("node valid", 0, nv);
    bus(0, 0, 0);
    chk("reg0 reset", 8'h55, q);
  endtask
  task automatic t_irq;
    bus(1, 6'h11, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq set", 1, irq);
    bus(0, 6'h10, 0);
    chk("status", 8'h03, q);
    bus(1, 6'h10, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("irq clear", 0, irq);
  endtask
  task automatic t_gap;
    bus(1, 1, 8'h05);
    #1 chk("gap write", 8'h05, gap);
    core.pulse(0, 0);
    #1 chk("gap one reset", 8'h05, gap);
    core.pulse(0, 0);
    #1 chk("gap two resets", 8'h3f, gap);
    core.pulse(2, 6'h0a);
    #1 chk("gap packet", 8'h0a, gap);
    core.pulse(3, 0);
    #1 chk("holdoff", 1, rh);
    chk("gap no field", 8'h0a, gap);
    core.pulse(0, 0);
    #1 chk("holdoff kept", 1, rh);
  endtask
  task automatic t_long;
    int n;
    n = 0;
    core.set_idle(1'b0);
    bus(0, 1, 0);
    chk("reg1", 8'h8a, q);
    bus(1, 1, q | 8'h40);
    bus(1, 5, 8'h40);
    repeat (5) @(posedge clk);
    chk("long wait", 0, lra);
    chk("short request", 1, srq);
    core.set_idle(1'b1);
    repeat (60) begin
      @(posedge clk);
      if (lra === 1'b1) n++;
    end
    chk("long length", 8'(LR), 8'(n));
    chk("short cleared", 0, srq);
    bus(0, 1, 0);
    chk("long cleared", 8'h8a, q);
  endtask
  // Hardware reset in mid-run returns the control fields
  task automatic t_hwrst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 1, 0);
    chk("reg1 after reset", 8'h3f, q);
    chk("holdoff after reset", 0, rh);
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_ro;
    t_sid;
    t_irq;
    t_gap;
    t_long;
    t_hwrst;
    end_of_test;
  end
endmodule
